// ==== rtl/rpc_pkg.sv ====
/*
 * constants of the receive port control registers: offsets, field positions,
 * reset values, write masks and receive mode codes.
 * assumes an 8-bit register access port driven by the serial control slave.
 */
// How it works
// - mode 0: lock and video need active video
// - mode 1: lock whenever linked to serializer
// - raw mode passes remote gpio unfiltered
// - input mode: auto, 2-lane, primary, secondary
// - port zero select writes/reads port 0 copies
// - port one select writes/reads port 1 copies
// - both selects set: reads return port 1
// - equalizer test register reads follow port one select
// - restart level restarts both ports; host clears
// - floor start only with floor override set
// - floor start begins adaptation at preset floor
// - forward video off status loaded from serializer
package rpc_pkg;

  localparam logic [7:0] RPC_CTRL_ADDR = 8'h34;
  localparam logic [7:0] RPC_EQ_ADDR = 8'h35;

  localparam logic [7:0] RPC_CTRL_RESET = 8'h01;
  localparam logic [7:0] RPC_EQ_RESET = 8'h00;
  localparam logic [7:0] RPC_CTRL_WMASK = 8'h7b;
  localparam logic [7:0] RPC_EQ_WMASK = 8'h70;

  localparam int RPC_LOCK_MODE_BIT = 6;
  localparam int RPC_RAW_BC_BIT = 5;
  localparam int RPC_MODE_HI_BIT = 4;
  localparam int RPC_MODE_LO_BIT = 3;
  localparam int RPC_PORT1_BIT = 1;
  localparam int RPC_PORT0_BIT = 0;

  localparam int RPC_RESTART_BIT = 6;
  localparam int RPC_FLOOR_OVR_BIT = 5;
  localparam int RPC_FLOOR_SET_BIT = 4;

  localparam int RPC_PORTS = 2;

  typedef enum logic [1:0] {
    RPC_MODE_AUTO = 2'b00,
    RPC_MODE_DUAL = 2'b01,
    RPC_MODE_PRIMARY = 2'b10,
    RPC_MODE_SECONDARY = 2'b11
  } rpc_input_mode_t;

endpackage : rpc_pkg

// ==== rtl/rpc_eq_if.sv ====
/*
 * per-port equalizer control carrier between the register bank and one
 * equalizer control copy.
 * assumes both ends run on the same register clock.
 */
`timescale 1ns/1ps

interface rpc_eq_if;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] value;
  logic restart;
  logic floor_start;

  modport ctl (output wr, output wdata, input value, input restart, input floor_start);
  modport eq (input wr, input wdata, output value, output restart, output floor_start);
endinterface : rpc_eq_if

// ==== rtl/rpc_eq_ctrl.sv ====
/*
 * one port copy of the equalizer test register and its decoded controls.
 * assumes writes are already steered to this port by the register bank.
 */
`timescale 1ns/1ps

module rpc_eq_ctrl (
  input wire logic mclk,
  input wire logic srst,
  rpc_eq_if.eq bus
);

  logic [7:0] value_q;
  logic [7:0] value_d;

  always_comb begin
    value_d = value_q;
    if (bus.wr) begin
      value_d = bus.wdata & rpc_pkg::RPC_EQ_WMASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      value_q <= rpc_pkg::RPC_EQ_RESET;
    end else begin
      value_q <= value_d;
    end
  end

  assign bus.value = value_q;
  assign bus.restart = value_q[rpc_pkg::RPC_RESTART_BIT];
  // preset floor only while the override enables it
  assign bus.floor_start = value_q[rpc_pkg::RPC_FLOOR_OVR_BIT] &
                           value_q[rpc_pkg::RPC_FLOOR_SET_BIT];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  reserved_zero_a: assert property ((value_q & ~rpc_pkg::RPC_EQ_WMASK) == 8'h00)
    else $error("reserved equalizer bits not zero");
  floor_gate_a: assert property (!value_q[rpc_pkg::RPC_FLOOR_OVR_BIT] |-> !bus.floor_start)
    else $error("floor start active without override");

endmodule : rpc_eq_ctrl

// ==== rtl/rpc_receive_port_control.sv ====
/*
 * receive port control register bank: lock indication mode, raw secondary
 * back channel, receive input mode, port steering of register access and
 * the per-port equalizer test controls.
 * assumes a register access port from the serial control slave, one access
 * per cycle, and link status inputs synchronous to mclk.
 */
`timescale 1ns/1ps

module rpc_receive_port_control (
  input wire logic mclk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_hit,
  output logic port_zero_write,
  output logic port_one_write,
  output logic port_one_read,
  input wire logic linked_to_serializer,
  input wire logic fc_load,
  input wire logic fc_video_off,
  output logic forward_video_off,
  output logic link_lock_indication,
  output logic video_generate,
  input wire logic remote_gpio_zero,
  input wire logic filtered_gpio_zero,
  output logic backchannel_tx,
  input wire logic detect_dual_lane,
  input wire logic detect_secondary,
  output logic rx_dual_lane,
  output logic rx_secondary_input,
  output logic [1:0] eq_restart,
  output logic [1:0] eq_floor_start
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic mode_dual(input logic [1:0] mode, input logic det);
    unique case (rpc_pkg::rpc_input_mode_t'(mode))
      rpc_pkg::RPC_MODE_AUTO: mode_dual = det;
      rpc_pkg::RPC_MODE_DUAL: mode_dual = 1'b1;
      rpc_pkg::RPC_MODE_PRIMARY: mode_dual = 1'b0;
      rpc_pkg::RPC_MODE_SECONDARY: mode_dual = 1'b0;
    endcase
  endfunction : mode_dual

  function automatic logic mode_second(input logic [1:0] mode, input logic det);
    unique case (rpc_pkg::rpc_input_mode_t'(mode))
      rpc_pkg::RPC_MODE_AUTO: mode_second = det;
      rpc_pkg::RPC_MODE_DUAL: mode_second = 1'b0;
      rpc_pkg::RPC_MODE_PRIMARY: mode_second = 1'b0;
      rpc_pkg::RPC_MODE_SECONDARY: mode_second = 1'b1;
    endcase
  endfunction : mode_second

  // ****************************************
  // register access
  // ****************************************
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic fvo_q;
  logic fvo_d;
  logic sel0;
  logic sel1;
  logic hit_ctrl;
  logic hit_eq;
  logic [1:0] eq_wr;

  rpc_eq_if eq_bus [rpc_pkg::RPC_PORTS] ();

  assign sel0 = ctrl_q[rpc_pkg::RPC_PORT0_BIT];
  assign sel1 = ctrl_q[rpc_pkg::RPC_PORT1_BIT];
  assign hit_ctrl = (reg_addr == rpc_pkg::RPC_CTRL_ADDR);
  assign hit_eq = (reg_addr == rpc_pkg::RPC_EQ_ADDR);
  assign reg_hit = (reg_wr | reg_rd) & (hit_ctrl | hit_eq);
  assign port_zero_write = sel0;
  assign port_one_write = sel1;
  assign port_one_read = sel1;
  // per-port copy written when its port is selected
  assign eq_wr[0] = reg_wr & hit_eq & sel0;
  assign eq_wr[1] = reg_wr & hit_eq & sel1;

  always_comb begin
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    rvalid_d = reg_rd;
    fvo_d = fvo_q;
    if (reg_wr && hit_ctrl) begin
      ctrl_d = reg_wdata & rpc_pkg::RPC_CTRL_WMASK;
    end
    if (reg_rd) begin
      if (hit_ctrl) begin
        rdata_d = ctrl_q;
      end else if (hit_eq) begin
        // port 1 copy wins when both selects are set
        rdata_d = sel1 ? eq_bus[1].value : eq_bus[0].value;
      end else begin
        rdata_d = 8'h00;
      end
    end
    if (fc_load) begin
      fvo_d = fc_video_off;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_q <= rpc_pkg::RPC_CTRL_RESET;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      fvo_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      fvo_q <= fvo_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign forward_video_off = fvo_q;

  // ****************************************
  // equalizer port copies
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < rpc_pkg::RPC_PORTS; gi++) begin : g_eq
      assign eq_bus[gi].wr = eq_wr[gi];
      assign eq_bus[gi].wdata = reg_wdata;
      rpc_eq_ctrl u_eq (
        .mclk(mclk),
        .srst(srst),
        .bus(eq_bus[gi])
      );
    end
  endgenerate

  // ****************************************
  // link side controls
  // ****************************************
  logic lock_q;
  logic lock_d;
  logic video_q;
  logic video_d;
  logic bc_q;
  logic bc_d;
  logic dual_q;
  logic dual_d;
  logic second_q;
  logic second_d;
  logic [1:0] restart_q;
  logic [1:0] restart_d;
  logic [1:0] floor_q;
  logic [1:0] floor_d;
  logic [1:0] mode;

  assign mode = ctrl_q[rpc_pkg::RPC_MODE_HI_BIT:rpc_pkg::RPC_MODE_LO_BIT];

  always_comb begin
    video_d = linked_to_serializer & ~fvo_q;
    if (ctrl_q[rpc_pkg::RPC_LOCK_MODE_BIT]) begin
      lock_d = linked_to_serializer;
    end else begin
      lock_d = linked_to_serializer & ~fvo_q;
    end
    bc_d = ctrl_q[rpc_pkg::RPC_RAW_BC_BIT] ? remote_gpio_zero : filtered_gpio_zero;
    dual_d = mode_dual(mode, detect_dual_lane);
    second_d = mode_second(mode, detect_secondary);
    // one restart level from either copy restarts both ports
    restart_d = {2{eq_bus[0].restart | eq_bus[1].restart}};
    floor_d = {eq_bus[1].floor_start, eq_bus[0].floor_start};
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      lock_q <= 1'b0;
      video_q <= 1'b0;
      bc_q <= 1'b0;
      dual_q <= 1'b0;
      second_q <= 1'b0;
      restart_q <= 2'b00;
      floor_q <= 2'b00;
    end else begin
      lock_q <= lock_d;
      video_q <= video_d;
      bc_q <= bc_d;
      dual_q <= dual_d;
      second_q <= second_d;
      restart_q <= restart_d;
      floor_q <= floor_d;
    end
  end

  assign link_lock_indication = lock_q;
  assign video_generate = video_q;
  assign backchannel_tx = bc_q;
  assign rx_dual_lane = dual_q;
  assign rx_secondary_input = second_q;
  assign eq_restart = restart_q;
  assign eq_floor_start = floor_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_write_eq;
    reg_wr && hit_eq && sel1;
  endsequence

  sequence s_read_eq;
    reg_rd && hit_eq && sel1;
  endsequence

  lock_mode0_a: assert property (!ctrl_q[rpc_pkg::RPC_LOCK_MODE_BIT] && linked_to_serializer &&
                                 fvo_q
                                 |=> !link_lock_indication)
    else $error("lock shown without active video in mode 0");
  lock_mode1_a: assert property (ctrl_q[rpc_pkg::RPC_LOCK_MODE_BIT] && linked_to_serializer
                                 |=> link_lock_indication)
    else $error("lock missing while linked in mode 1");
  video_gate_a: assert property (video_generate |-> $past(fvo_q) == 1'b0)
    else $error("video generated while forward video off");
  raw_bc_a: assert property (ctrl_q[rpc_pkg::RPC_RAW_BC_BIT]
                             |=> backchannel_tx == $past(remote_gpio_zero))
    else $error("raw back channel not passing remote gpio");
  forced_dual_a: assert property (mode == rpc_pkg::RPC_MODE_DUAL
                                  |=> rx_dual_lane && !rx_secondary_input)
    else $error("forced 2-lane mode not applied");
  forced_second_a: assert property (mode == rpc_pkg::RPC_MODE_SECONDARY
                                    |=> !rx_dual_lane && rx_secondary_input)
    else $error("forced secondary mode not applied");
  port1_write_a: assert property (s_write_eq ##1 s_read_eq
                                  |=> reg_rdata == ($past(reg_wdata, 2) &
                                                    rpc_pkg::RPC_EQ_WMASK))
    else $error("port 1 copy not written or read back");
  port0_read_a: assert property (reg_rd && hit_eq && sel0 && !sel1
                                 |=> reg_rdata == $past(eq_bus[0].value))
    else $error("port 0 copy not returned");
  both_sel_a: assert property (reg_rd && hit_eq && sel0 && sel1
                               |=> reg_rdata == $past(eq_bus[1].value))
    else $error("port 1 copy not preferred");
  restart_both_a: assert property ((eq_bus[0].restart || eq_bus[1].restart)
                                   |=> eq_restart == 2'b11)
    else $error("restart not applied to both ports");
  ctrl_resv_a: assert property ((ctrl_q & ~rpc_pkg::RPC_CTRL_WMASK) == 8'h00)
    else $error("reserved control bits not zero");
  fvo_load_a: assert property (fc_load |=> forward_video_off == $past(fc_video_off))
    else $error("forward video off not loaded");

endmodule : rpc_receive_port_control

// ==== testbench/rpc_serializer_model.sv ====
/*
 * behavioural remote serializer: link state and forward channel loading.
 * assumes the bench steers link_up and video_off away from the clock edge.
 */
`timescale 1ns/1ps

module rpc_serializer_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic link_up,
  input wire logic video_off,
  output logic linked_to_serializer,
  output logic fc_load,
  output logic fc_video_off
);
  logic sent_q;

  // loads the video off status only on change, toggles between loads
  always_ff @(posedge mclk) begin
    if (srst) begin
      sent_q <= 1'b0;
      fc_load <= 1'b0;
      fc_video_off <= 1'b0;
      linked_to_serializer <= 1'b0;
    end else begin
      linked_to_serializer <= link_up;
      fc_load <= (video_off != sent_q);
      fc_video_off <= (video_off != sent_q) ? video_off : ~fc_video_off;
      sent_q <= video_off;
    end
  end
endmodule : rpc_serializer_model

// ==== testbench/rpc_receive_port_control_bench.sv ====
/*
 * self-checking bench of the receive port control register bank.
 * assumes the register access port and link inputs of the bank top module.
 */
`timescale 1ns/1ps

module rpc_receive_port_control_bench;
  logic mclk, srst, reg_wr, reg_rd, reg_rvalid, reg_hit, pzw, pow, por, link_up, video_off;
  logic linked, fcl, fcv, fvo, lock, vgen, g_raw, g_filt, bc_tx, d_dual, d_sec, rx_dual, rx_sec;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] eq_rst, eq_floor;
  int n_mismatch = 0;
  int check_count = 0;
  localparam logic [7:0] MODE_EXP = 8'h4b;

  rpc_serializer_model ser (.mclk(mclk), .srst(srst), .link_up(link_up),
    .video_off(video_off), .linked_to_serializer(linked), .fc_load(fcl), .fc_video_off(fcv));

  rpc_receive_port_control dut (.mclk(mclk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .port_zero_write(pzw),
    .port_one_write(pow), .port_one_read(por), .linked_to_serializer(linked),
    .fc_load(fcl), .fc_video_off(fcv), .forward_video_off(fvo),
    .link_lock_indication(lock), .video_generate(vgen), .remote_gpio_zero(g_raw),
    .filtered_gpio_zero(g_filt), .backchannel_tx(bc_tx), .detect_dual_lane(d_dual),
    .detect_secondary(d_sec), .rx_dual_lane(rx_dual), .rx_secondary_input(rx_sec),
    .eq_restart(eq_rst), .eq_floor_start(eq_floor));

  /****************************************/
  /* helpers                              */
  /****************************************/
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(negedge mclk);
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    #1 chk({7'h00, reg_hit}, {7'h00, (a == 8'h34) || (a == 8'h35)});
    @(negedge mclk);
    chk({7'h00, reg_rvalid}, 8'h01);
    chk(reg_rdata, exp);
    reg_rd = 1'b0;
  endtask : rd_chk

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  /****************************************/
  /* scenarios                            */
  /****************************************/
  task automatic t_reset_mask;
    rd_chk(8'h34, 8'h01);
    rd_chk(8'h35, 8'h00);
    rd_chk(8'h40, 8'h00);
    wr(8'h34, 8'hff);
    rd_chk(8'h34, 8'h7b);
    wr(8'h35, 8'hff);
    rd_chk(8'h35, 8'h70);
    wr(8'h35, 8'h00);
    wr(8'h34, 8'h01);
  endtask : t_reset_mask

  task automatic t_lock;
    link_up = 1'b1;
    settle(5);
    chk({5'h0, fvo, lock, vgen}, 8'h03);
    video_off = 1'b1;
    settle(5);
    chk({5'h0, fvo, lock, vgen}, 8'h04);
    wr(8'h34, 8'h41);
    settle(3);
    chk({5'h0, fvo, lock, vgen}, 8'h06);
    link_up = 1'b0;
    settle(5);
    chk({5'h0, fvo, lock, vgen}, 8'h04);
    link_up = 1'b1;
    video_off = 1'b0;
    wr(8'h34, 8'h01);
  endtask : t_lock

  task automatic t_raw;
    g_raw = 1'b1;
    g_filt = 1'b0;
    settle(3);
    chk({7'h0, bc_tx}, 8'h00);
    wr(8'h34, 8'h21);
    settle(3);
    chk({7'h0, bc_tx}, 8'h01);
    wr(8'h34, 8'h01);
  endtask : t_raw

  task automatic t_mode;
    d_dual = 1'b1;
    d_sec = 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(8'h34, {3'h0, 2'(m), 3'h1});
      settle(3);
      chk({6'h0, rx_dual, rx_sec}, {6'h0, MODE_EXP[2*m+:2]});
    end
    wr(8'h34, 8'h01);
    d_dual = 1'b0;
    d_sec = 1'b0;
    settle(3);
    chk({6'h0, rx_dual, rx_sec}, 8'h00);
  endtask : t_mode

  task automatic t_ports;
    chk({5'h0, pzw, pow, por}, 8'h04);
    wr(8'h35, 8'h30);
    rd_chk(8'h35, 8'h30);
    settle(2);
    chk({6'h0, eq_floor}, 8'h01);
    wr(8'h34, 8'h02);
    settle(2);
    chk({5'h0, pzw, pow, por}, 8'h03);
    rd_chk(8'h35, 8'h00);
    wr(8'h35, 8'h10);
    settle(2);
    chk({6'h0, eq_floor}, 8'h01);
    wr(8'h34, 8'h03);
    rd_chk(8'h35, 8'h10);
    wr(8'h35, 8'h00);
    wr(8'h34, 8'h02);
    wr(8'h35, 8'h70);
    settle(2);
    chk({6'h0, eq_rst}, 8'h03);
    chk({6'h0, eq_floor}, 8'h02);
    wr(8'h35, 8'h30);
    settle(2);
    chk({6'h0, eq_rst}, 8'h00);
    wr(8'h34, 8'h01);
    rd_chk(8'h35, 8'h00);
  endtask : t_ports

  /****************************************/
  /* clock, reset, sequence, watchdog     */
  /****************************************/
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    srst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {link_up, video_off, g_raw, g_filt, d_dual, d_sec} = '0;
    repeat (6) @(negedge mclk);
    srst = 1'b0;
    t_reset_mask();
    t_lock();
    t_raw();
    t_mode();
    t_ports();
    end_of_test();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    end_of_test();
  end
endmodule : rpc_receive_port_control_bench
